// ---- common/ppio_pkg.sv ----
// package of constants and types for the panel parallel i/o ports
package ppio_pkg;
  // i/o address map
  localparam logic [7:0] PPIO_ADDR_DISP_LO  = 8'he4;  // display/keyboard window start
  localparam logic [7:0] PPIO_ADDR_DISP_HI  = 8'he7;  // display/keyboard window end
  localparam logic [7:0] PPIO_ADDR_FIRST    = 8'he8;  // panel_port_first_data
  localparam logic [7:0] PPIO_ADDR_SECOND   = 8'he9;  // panel_port_second_data
  localparam logic [7:0] PPIO_ADDR_THIRD    = 8'hea;  // panel_port_third_data
  localparam logic [7:0] PPIO_ADDR_CTRL     = 8'heb;  // panel_port_direction_control
  // control words
  localparam logic [7:0] PPIO_CW_ALL_OUT    = 8'h80;
  localparam logic [7:0] PPIO_CW_C_LO_IN    = 8'h81;
  localparam logic [7:0] PPIO_CW_B_IN       = 8'h82;
  localparam logic [7:0] PPIO_CW_B_CLO_IN   = 8'h83;
  localparam logic [7:0] PPIO_CW_STB_OUT0   = 8'h84;
  localparam logic [7:0] PPIO_CW_STB_OUT1   = 8'h85;
  localparam logic [7:0] PPIO_CW_STB_IN0    = 8'h86;
  localparam logic [7:0] PPIO_CW_STB_IN1    = 8'h87;
  // field positions of strobes within the third port
  localparam int        PPIO_STB_REQ_BIT   = 0;  // strobe from panel (ack or load)
  localparam int        PPIO_STB_FLAG_BIT  = 1;  // buffer-full flag to panel
  localparam int        PPIO_STB_INT_BIT   = 2;  // ready indication to panel
  // reset values
  localparam logic [7:0] PPIO_DATA_RST      = 8'h00;
  localparam logic [3:0] PPIO_MODE_RST      = 4'h0;  // all inputs until first word
  // decoded direction mode
  typedef enum logic [2:0] {
    PPIO_M_SAFE   = 3'b000,  // after reset: every line input
    PPIO_M_OUT    = 3'b001,
    PPIO_M_CLO_IN = 3'b010,
    PPIO_M_B_IN   = 3'b011,
    PPIO_M_BC_IN  = 3'b100,
    PPIO_M_STBOUT = 3'b101,
    PPIO_M_STBIN  = 3'b110
  } ppio_mode_e;
  // direction enables per port group
  typedef struct packed {
    logic oe_a;
    logic oe_b;
    logic oe_chi;
    logic oe_clo;
  } ppio_dir_s;
  // map a mode to output enables
  function automatic ppio_dir_s ppio_dir_of(input ppio_mode_e m);
    ppio_dir_s d;
    d = '{oe_a: 1'b1, oe_b: 1'b1, oe_chi: 1'b1, oe_clo: 1'b1};
    unique case (m)
      PPIO_M_SAFE:   d = '{oe_a: 1'b0, oe_b: 1'b0, oe_chi: 1'b0, oe_clo: 1'b0};
      PPIO_M_OUT:    d = d;
      PPIO_M_CLO_IN: d.oe_clo = 1'b0;
      PPIO_M_B_IN:   d.oe_b = 1'b0;
      PPIO_M_BC_IN:  begin
        d.oe_b   = 1'b0;
        d.oe_clo = 1'b0;
      end
      PPIO_M_STBOUT: d.oe_clo = 1'b0;  // bits 2..0 are handshake
      PPIO_M_STBIN:  begin
        d.oe_b   = 1'b0;  // second port is the strobed input
        d.oe_clo = 1'b0;
      end
      default:       d = '{oe_a: 1'b0, oe_b: 1'b0, oe_chi: 1'b0, oe_clo: 1'b0};
    endcase
    return d;
  endfunction
endpackage

// ---- common/ppio_bus_if.sv ----
// interface carrying decoded bus strobes between decoder and port core
`timescale 1ns/1ns
`default_nettype none
interface ppio_bus_if;
  logic       wr;     // write strobe to panel range
  logic       rd;     // read strobe to panel range
  logic [1:0] sel;    // register select within panel range
  logic [7:0] wdata;  // write data
  modport dec  (output wr, output rd, output sel, output wdata);
  modport core (input wr, input rd, input sel, input wdata);
endinterface
`default_nettype wire

// ---- design/ppio_decode.sv ----
// i/o address decoder for the panel port window
`timescale 1ns/1ns
`default_nettype none
module ppio_decode
  import ppio_pkg::*;
(
  input  wire logic       io_wr,    // processor i/o write
  input  wire logic       io_rd,    // processor i/o read
  input  wire logic [7:0] io_addr,  // processor i/o address
  input  wire logic [7:0] io_wdata, // processor write data
  output logic            hit,      // address falls in panel window
  output logic            disp_sel, // address falls in display/keyboard window
  ppio_bus_if.dec         bus       // decoded strobes to core
);
  // panel window e8..eb; display window e4..e7 is kept out
  always_comb begin
    disp_sel  = (io_addr >= PPIO_ADDR_DISP_LO) && (io_addr <= PPIO_ADDR_DISP_HI);
    hit       = (io_addr >= PPIO_ADDR_FIRST) && (io_addr <= PPIO_ADDR_CTRL);
    bus.wr    = io_wr && hit && !disp_sel;
    bus.rd    = io_rd && hit && !disp_sel;
    bus.sel   = io_addr[1:0];
    bus.wdata = io_wdata;
  end
endmodule // ppio_decode
`default_nettype wire

// ---- design/ppio_ctrl.sv ----
// control-word register and mode decode
`timescale 1ns/1ns
`default_nettype none
module ppio_ctrl
  import ppio_pkg::*;
(
  input  wire logic       clk,       // system clock
  input  wire logic       rst_n,     // synchronous reset, active low
  ppio_bus_if.core        bus,       // decoded strobes
  output ppio_mode_e      mode,      // current direction mode
  output logic            mode_chg   // pulse: a new control word took effect
);
  typedef struct packed {
    ppio_mode_e mode;
    logic       chg;
  } ppio_cst_s;
  ppio_cst_s st_r, st_nxt;  // state and next
  // only a write to the control register changes direction
  always_comb begin
    st_nxt     = st_r;
    st_nxt.chg = 1'b0;
    if (bus.wr && bus.sel == PPIO_ADDR_CTRL[1:0]) begin
      st_nxt.chg = 1'b1;
      unique case (bus.wdata)
        PPIO_CW_ALL_OUT:  st_nxt.mode = PPIO_M_OUT;
        PPIO_CW_C_LO_IN:  st_nxt.mode = PPIO_M_CLO_IN;
        PPIO_CW_B_IN:     st_nxt.mode = PPIO_M_B_IN;
        PPIO_CW_B_CLO_IN: st_nxt.mode = PPIO_M_BC_IN;
        PPIO_CW_STB_OUT0,
        PPIO_CW_STB_OUT1: st_nxt.mode = PPIO_M_STBOUT;
        PPIO_CW_STB_IN0,
        PPIO_CW_STB_IN1:  st_nxt.mode = PPIO_M_STBIN;
        default:          st_nxt.chg  = 1'b0;  // undefined words ignored
      endcase
    end
  end
  // register state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '{mode: PPIO_M_SAFE, chg: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign mode     = st_r.mode;
  assign mode_chg = st_r.chg;
  // assertions
  a_cw_all_out: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.sel == 2'b11 && bus.wdata == PPIO_CW_ALL_OUT |=> mode == PPIO_M_OUT)
    else $error("word 80 did not select all outputs");
  a_cw_clo_in: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.sel == 2'b11 && bus.wdata == PPIO_CW_C_LO_IN |=> mode == PPIO_M_CLO_IN)
    else $error("word 81 did not select low nibble input");
  a_cw_b_in: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.sel == 2'b11 && bus.wdata == PPIO_CW_B_IN |=> mode == PPIO_M_B_IN)
    else $error("word 82 did not select second port input");
  a_cw_bc_in: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.sel == 2'b11 && bus.wdata == PPIO_CW_B_CLO_IN |=> mode == PPIO_M_BC_IN)
    else $error("word 83 did not select second port and nibble input");
  a_mode_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(bus.wr && bus.sel == 2'b11) |=> $stable(mode))
    else $error("direction changed without a control write");
  c_stb_out: cover property (@(posedge clk) disable iff (!rst_n) mode == PPIO_M_STBOUT);
  c_stb_in:  cover property (@(posedge clk) disable iff (!rst_n) mode == PPIO_M_STBIN);
endmodule // ppio_ctrl
`default_nettype wire

// ---- design/ppio_top.sv ----
// panel parallel i/o ports: three 8-line ports behind the processor i/o bus
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ppio_top
  import ppio_pkg::*;
#(
  parameter int W = 8  // lines per port
)(
  input  wire logic         CLK,        // system clock, 250 MHz
  input  wire logic         RESET_N,    // synchronous reset, active low
  input  wire logic         IO_WR,      // i/o write strobe
  input  wire logic         IO_RD,      // i/o read strobe
  input  wire logic [7:0]   IO_ADDR,    // i/o port address
  input  wire logic [7:0]   IO_WDATA,   // write data
  output logic      [7:0]   IO_RDATA,   // read data, registered
  output logic              IO_RVALID,  // read data valid pulse
  output logic              DISP_SEL,   // address is display/keyboard window
  input  wire logic [W-1:0] PA_IN_N,    // first port pins in, active low
  output logic      [W-1:0] PA_OUT_N,   // first port pins out, active low
  output logic      [W-1:0] PA_OE,      // first port output enable
  input  wire logic [W-1:0] PB_IN_N,    // second port pins / latch switches in
  output logic      [W-1:0] PB_OUT_N,   // second port pins out
  output logic      [W-1:0] PB_OE,      // second port output enable
  input  wire logic [W-1:0] PC_IN_N,    // third port pins in
  output logic      [W-1:0] PC_OUT_N,   // third port pins out
  output logic      [W-1:0] PC_OE,      // third port output enable
  output logic      [W-1:0] LED_A_N,    // first port indicators, active low
  output logic      [W-1:0] LED_B_N     // second port indicators, active low
);
  ////////////////////////////////////////////////////////////////////////////
  // decode and control word
  // decode is combinational: a write acts
  // at the very next clock edge
  // the mode has a single owner, ppio_ctrl
  ppio_bus_if bus ();   // decoded strobes
  ppio_mode_e mode;     // current direction mode
  logic       mode_chg; // new word pulse
  logic       hit;      // panel window hit
  ppio_decode u_dec (
    .io_wr    (IO_WR),
    .io_rd    (IO_RD),
    .io_addr  (IO_ADDR),
    .io_wdata (IO_WDATA),
    .hit      (hit),
    .disp_sel (DISP_SEL),
    .bus      (bus.dec)
  );
  ppio_ctrl u_ctrl (
    .clk      (CLK),
    .rst_n    (RESET_N),
    .bus      (bus.core),
    .mode     (mode),
    .mode_chg (mode_chg)
  );
  ////////////////////////////////////////////////////////////////////////////
  // state
  // bin is apart from b: the panel may load
  // input while b keeps the written byte
  typedef struct packed {
    logic [W-1:0] a;      // first port output latch
    logic [W-1:0] b;      // second port output latch
    logic [W-1:0] c;      // third port output latch
    logic [W-1:0] bin;    // second port strobed-input latch
    logic         obf;    // output buffer full (strobed out)
    logic         ibf;    // input buffer full (strobed in)
    logic         stb_d;  // previous strobe level, for edge
    logic [7:0]   rdata;  // read data
    logic         rvalid; // read pulse
  } ppio_st_s;
  ppio_st_s st_r, st_nxt;
  ppio_dir_s dir;        // current output enables
  logic [W-1:0] a_in;    // pins inverted to positive logic
  logic [W-1:0] b_in;
  logic [W-1:0] c_in;
  logic         stb;     // panel strobe, positive logic
  logic         stb_fall;// strobe release edge
  logic         strobed; // a strobed mode is active
  logic [W-1:0] c_eff;   // third port value with handshake bits merged
  logic [3:0]   c_lo_rd; // third port low nibble as read back
  ////////////////////////////////////////////////////////////////////////////
  // pin polarity: negative true on every line
  // inverting once here keeps the core in
  // positive logic up to the pin drive
  always_comb begin
    a_in     = ~PA_IN_N;
    b_in     = ~PB_IN_N;
    c_in     = ~PC_IN_N;
    dir      = ppio_dir_of(mode);
    strobed  = (mode == PPIO_M_STBOUT) || (mode == PPIO_M_STBIN);
    stb      = c_in[PPIO_STB_REQ_BIT];
    stb_fall = st_r.stb_d && !stb;
  end
  ////////////////////////////////////////////////////////////////////////////
  // third port: handshake bits driven by the core in strobed modes
  // flags replace latch bits 2..1 so a data
  // write cannot fake a handshake
  always_comb begin
    c_eff = st_r.c;
    if (mode == PPIO_M_STBOUT) begin
      c_eff[PPIO_STB_FLAG_BIT] = st_r.obf;
      c_eff[PPIO_STB_INT_BIT]  = !st_r.obf;
    end else if (mode == PPIO_M_STBIN) begin
      c_eff[PPIO_STB_FLAG_BIT] = st_r.ibf;
      c_eff[PPIO_STB_INT_BIT]  = st_r.ibf;
    end
    // low nibble as read: pins where input,
    // handshake flags where the core drives
    c_lo_rd = c_eff[3:0];
    if (!dir.oe_clo) begin
      c_lo_rd = strobed ? {c_in[3], c_eff[2:1], c_in[0]} : c_in[3:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // next state: latches, handshake flags, read mux
  // branch order is priority, the later branch wins:
  // word change, panel edge, write, read, then load
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.stb_d  = stb;
    // a new word restarts the handshake with empty buffers
    if (mode_chg) begin
      st_nxt.obf = 1'b0;
      st_nxt.ibf = 1'b0;
    end
    // panel side of the handshake; a same-cycle set below wins over this clear
    if (mode == PPIO_M_STBOUT && stb_fall) begin
      st_nxt.obf = 1'b0;
    end
    // writes to the data latches
    if (bus.wr) begin
      unique case (bus.sel)
        2'b00: st_nxt.a = bus.wdata[W-1:0];
        2'b01: begin
          st_nxt.b = bus.wdata[W-1:0];
          if (mode == PPIO_M_STBOUT) st_nxt.obf = 1'b1;
        end
        2'b10: st_nxt.c = bus.wdata[W-1:0];
        2'b11: st_nxt.c = st_r.c;  // control word, handled in ppio_ctrl
      endcase
    end
    // reads: output latches read back, inputs read the pins, the strobed input reads its latch
    if (bus.rd) begin
      st_nxt.rvalid = 1'b1;
      unique case (bus.sel)
        2'b00: st_nxt.rdata = dir.oe_a ? st_r.a : a_in;
        2'b01: begin
          if (mode == PPIO_M_STBIN) begin
            st_nxt.rdata = st_r.bin;
            st_nxt.ibf   = 1'b0;
          end else begin
            st_nxt.rdata = dir.oe_b ? st_r.b : b_in;
          end
        end
        2'b10: st_nxt.rdata = {dir.oe_chi ? c_eff[7:4] : c_in[7:4], c_lo_rd};
        2'b11: st_nxt.rdata = 8'h00; // control register is write only
      endcase
    end
    // strobed input: panel strobe loads the second port; load beats read clear
    if (mode == PPIO_M_STBIN && stb && !st_r.stb_d) begin
      st_nxt.bin = b_in;
      st_nxt.ibf = 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // register all state
  // stb_d resets low, like the idle strobe pin
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin drive: logic one shows as low level; strobes lines 2..1 driven in strobed modes
  // a released line floats high, logic zero,
  // so wire-anding with the panel is safe
  always_comb begin
    PA_OUT_N  = ~st_r.a;
    PB_OUT_N  = ~st_r.b;
    PC_OUT_N  = ~c_eff;
    PA_OE     = {W{dir.oe_a}};
    PB_OE     = {W{dir.oe_b}};
    PC_OE     = {{4{dir.oe_chi}}, {4{dir.oe_clo}}};
    if (strobed) begin
      PC_OE[PPIO_STB_FLAG_BIT] = 1'b1;
      PC_OE[PPIO_STB_INT_BIT]  = 1'b1;
    end
    // indicators show the line value, output latch or switch input
    LED_A_N   = dir.oe_a ? ~st_r.a : PA_IN_N;
    LED_B_N   = dir.oe_b ? ~st_r.b : PB_IN_N;
    IO_RDATA  = st_r.rdata;
    IO_RVALID = st_r.rvalid;
  end
  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // they watch pins and flags, and inside the core
  // the mode, bus strobes and latches
  a_disp_excluded: assert property (@(posedge CLK) disable iff (!RESET_N)
    IO_ADDR >= 8'he4 && IO_ADDR <= 8'he7 |-> !bus.wr && !bus.rd)
    else $error("display window reached panel ports");
  a_panel_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    IO_WR && IO_ADDR == 8'he8 |=> PA_OUT_N == ~$past(IO_WDATA))
    else $error("first port write not latched");
  a_active_low: assert property (@(posedge CLK) disable iff (!RESET_N)
    IO_WR && IO_ADDR == 8'he9 && (&PB_OE) |=> LED_B_N == ~$past(IO_WDATA))
    else $error("indicator polarity wrong");
  a_reset_safe: assert property (@(posedge CLK)
    !RESET_N |=> PA_OE == '0 && PB_OE == '0 && PC_OE == '0)
    else $error("ports not inputs after reset");
  a_readback: assert property (@(posedge CLK) disable iff (!RESET_N)
    IO_RD && IO_ADDR == 8'he8 && PA_OE[0] && !IO_WR |=> IO_RVALID && IO_RDATA == st_r.a)
    else $error("output port read back wrong");
  a_b_input: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_B_IN |-> PB_OE == '0 && PA_OE == {W{1'b1}})
    else $error("second port not input in mode 82");
  a_clo_input: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_CLO_IN |-> PC_OE == 8'hf0)
    else $error("third port nibble directions wrong");
  a_all_out: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_OUT |-> (&PA_OE) && (&PB_OE) && (&PC_OE))
    else $error("not all outputs in mode 80");
  a_obf_set: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_STBOUT && bus.wr && bus.sel == 2'b01 |=> st_r.obf)
    else $error("strobed output flag not set");
  // direction of the remaining modes
  a_bc_input: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_BC_IN |-> PB_OE == '0 && PC_OE == 8'hf0)
    else $error("mode 83 directions wrong");
  a_stbout_dir: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_STBOUT |-> (&PB_OE) && PC_OE == 8'hf6)
    else $error("strobed output directions wrong");
  a_stbin_dir: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_STBIN |-> PB_OE == '0 && PC_OE == 8'hf6)
    else $error("strobed input directions wrong");
  // handshake flags and their pins
  a_ibf_load: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_STBIN && stb && !st_r.stb_d
    |=> st_r.ibf && st_r.bin == $past(b_in))
    else $error("strobe did not load the input buffer");
  a_ibf_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_STBIN && bus.rd && bus.sel == 2'b01 && !stb |=> !st_r.ibf)
    else $error("read did not empty the input buffer");
  a_obf_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_STBOUT && stb_fall && !bus.wr |=> !st_r.obf)
    else $error("panel strobe did not empty the output buffer");
  a_hshk_pins: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode == PPIO_M_STBOUT |-> {PC_OUT_N[2], PC_OUT_N[1]} == {st_r.obf, !st_r.obf})
    else $error("handshake pins do not follow the flag");
  // indicators and the reserved window
  a_led_input: assert property (@(posedge CLK) disable iff (!RESET_N)
    !PB_OE[0] |-> LED_B_N == PB_IN_N)
    else $error("indicators do not show the switches");
  a_disp_no_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    IO_RD && DISP_SEL |=> !IO_RVALID)
    else $error("display window answered a read");
  c_read_pin:   cover property (@(posedge CLK) disable iff (!RESET_N) IO_RVALID && !PB_OE[0]);
  c_load_in:    cover property (@(posedge CLK) disable iff (!RESET_N) st_r.ibf);
  c_disp_hit:   cover property (@(posedge CLK) disable iff (!RESET_N) DISP_SEL && IO_WR);
endmodule // ppio_top
`default_nettype wire

// ---- testbench/ppio_panel_model.sv ----
// panel connector model: the far side of the three panel ports
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ppio_panel_model #(
  parameter int W = 8  // lines per port
)(
  input  wire logic         clk,      // system clock, used for strobe timing
  input  wire logic [W-1:0] a_out_n,  // first port device drive
  input  wire logic [W-1:0] a_oe,     // first port device enable
  input  wire logic [W-1:0] b_out_n,  // second port device drive
  input  wire logic [W-1:0] b_oe,     // second port device enable
  input  wire logic [W-1:0] c_out_n,  // third port device drive
  input  wire logic [W-1:0] c_oe,     // third port device enable
  output logic      [W-1:0] a_in_n,   // resolved first port pins
  output logic      [W-1:0] b_in_n,   // resolved second port pins
  output logic      [W-1:0] c_in_n    // resolved third port pins
);
  logic [W-1:0] drv_n [3];  // panel drive levels, pin polarity
  logic [W-1:0] en    [3];  // panel drive enables
  // undriven ttl lines float high, so released lines read as logic zero
  initial begin
    for (int p = 0; p < 3; p++) begin
      drv_n[p] = '1;
      en[p]    = '0;
    end
  end
  // wire-and of both parties: a low from either side wins
  assign a_in_n = (a_out_n | ~a_oe) & (drv_n[0] | ~en[0]);
  assign b_in_n = (b_out_n | ~b_oe) & (drv_n[1] | ~en[1]);
  assign c_in_n = (c_out_n | ~c_oe) & (drv_n[2] | ~en[2]);
  // drive a positive value on the lines of mask, inverted on the pins
  task automatic drive(input int p, input logic [W-1:0] val, input logic [W-1:0] mask);
    drv_n[p] = ~val;
    en[p]    = mask;
  endtask
  // latch switches: data on second port, strobe low on third port bit 0
  task automatic strobe(input logic [W-1:0] val, input int hold);
    drive(1, val, '1);
    drv_n[2][0] = 1'b0;
    en[2][0]    = 1'b1;
    repeat (hold) @(posedge clk);
    #1;
    en[2][0] = 1'b0;  // strobe released, line floats high
    en[1]    = '0;    // data withdrawn, so a late sample would differ
  endtask
endmodule  // ppio_panel_model
`default_nettype wire

// ---- testbench/panel_parallel_io_ports_tb_top.sv ----
// self-checking testbench for the panel parallel i/o ports
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module panel_parallel_io_ports_tb_top;
  import ppio_pkg::*;
  localparam int W = 8;  // lines per port
  logic         clk, reset_n, io_wr, io_rd, io_rvalid, disp_sel;  // bus and control
  logic [7:0]   io_addr, io_wdata, io_rdata;                        // bus data
  logic [W-1:0] pa_in_n, pa_out_n, pa_oe, pb_in_n, pb_out_n, pb_oe;  // pins
  logic [W-1:0] pc_in_n, pc_out_n, pc_oe, led_a_n, led_b_n;          // pins, lamps
  int           errors  = 0;  // mismatches
  int           n_tests = 0;  // comparisons made
  ppio_top #(.W(W)) i_ppio_top (.CLK(clk), .RESET_N(reset_n), .IO_WR(io_wr),
    .IO_RD(io_rd), .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata),
    .IO_RVALID(io_rvalid), .DISP_SEL(disp_sel), .PA_IN_N(pa_in_n), .PA_OUT_N(pa_out_n),
    .PA_OE(pa_oe), .PB_IN_N(pb_in_n), .PB_OUT_N(pb_out_n), .PB_OE(pb_oe),
    .PC_IN_N(pc_in_n), .PC_OUT_N(pc_out_n), .PC_OE(pc_oe), .LED_A_N(led_a_n),
    .LED_B_N(led_b_n));
  ppio_panel_model #(.W(W)) i_ppio_panel_model (.clk(clk), .a_out_n(pa_out_n),
    .a_oe(pa_oe), .b_out_n(pb_out_n), .b_oe(pb_oe), .c_out_n(pc_out_n), .c_oe(pc_oe),
    .a_in_n(pa_in_n), .b_in_n(pb_in_n), .c_in_n(pc_in_n));
  // 250 mhz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // closing report, the single exit of the run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs move 1 ns after the rising edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // one write cycle, then one cycle for the outputs to follow
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    tick();
    io_wr = 1'b0;
    tick();
  endtask
  // one read cycle; the answer is awaited for a bounded number of cycles
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic got;
    got     = 1'b0;
    io_addr = a;
    io_rd   = 1'b1;
    tick();
    io_rd = 1'b0;
    for (int i = 0; i < 4 && !got; i++) begin
      if (io_rvalid === 1'b1) begin
        got = 1'b1;
        chk(io_rdata, exp);
      end else begin
        tick();
      end
    end
    if (!got) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
      report_and_stop();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // every line must be an input, and the read data zero, until the first word
  task automatic t_reset();
    chk(pa_oe, 8'h00);
    chk(pb_oe, 8'h00);
    chk(pc_oe, 8'h00);
    chk(io_rdata, 8'h00);
    $display("test reset done");
  endtask
  // the direction words, each checked on all three enables
  task automatic t_modes();
    logic [7:0] cw [6] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h85, 8'h87};
    logic [7:0] eb [6] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00};
    logic [7:0] ec [6] = '{8'hff, 8'hf0, 8'hff, 8'hf0, 8'hf6, 8'hf6};
    for (int i = 0; i < 6; i++) begin
      wr(PPIO_ADDR_CTRL, cw[i]);
      chk(pa_oe, 8'hff);
      chk(pb_oe, eb[i]);
      chk(pc_oe, ec[i]);
    end
    $display("test modes done");
  endtask
  // output latches show inverted on pins and lamps; the first and third read back
  task automatic t_data();
    wr(PPIO_ADDR_CTRL, 8'h80);
    wr(PPIO_ADDR_FIRST, 8'h5a);
    wr(PPIO_ADDR_SECOND, 8'h0f);
    wr(PPIO_ADDR_THIRD, 8'hc3);
    chk(pa_out_n, 8'ha5);
    chk(led_a_n, 8'ha5);
    chk(pb_out_n, 8'hf0);
    chk(led_b_n, 8'hf0);
    chk(pc_out_n, 8'h3c);
    rd_chk(PPIO_ADDR_FIRST, 8'h5a);
    rd_chk(PPIO_ADDR_THIRD, 8'hc3);
    $display("test data done");
  endtask
  // input lines return the pin level in positive logic
  task automatic t_inputs();
    wr(PPIO_ADDR_CTRL, 8'h82);
    i_ppio_panel_model.drive(1, 8'h6c, 8'hff);
    tick();
    chk(led_b_n, 8'h93);
    rd_chk(PPIO_ADDR_SECOND, 8'h6c);
    wr(PPIO_ADDR_CTRL, 8'h81);
    i_ppio_panel_model.drive(2, 8'h05, 8'h0f);
    wr(PPIO_ADDR_THIRD, 8'h30);
    rd_chk(PPIO_ADDR_THIRD, 8'h35);
    i_ppio_panel_model.drive(1, 8'h00, 8'h00);
    i_ppio_panel_model.drive(2, 8'h00, 8'h00);
    $display("test inputs done");
  endtask
  // reserved window and undefined words leave the ports alone
  task automatic t_reserved();
    logic seen;
    seen = 1'b0;
    wr(PPIO_ADDR_CTRL, 8'h80);
    wr(PPIO_ADDR_FIRST, 8'h5a);
    for (int a = 'he4; a <= 'he7; a++) begin
      io_addr  = 8'(a);
      io_wdata = 8'hff;
      io_wr    = 1'b1;
      tick();
      chk({7'h00, disp_sel}, 8'h01);
      io_wr = 1'b0;
      tick();
    end
    chk(pa_out_n, 8'ha5);
    io_addr = 8'he5;
    io_rd   = 1'b1;
    tick();
    io_rd = 1'b0;
    repeat (3) begin
      seen = seen | (io_rvalid !== 1'b0);
      tick();
    end
    chk({7'h00, seen}, 8'h00);
    wr(PPIO_ADDR_CTRL, 8'h82);
    wr(PPIO_ADDR_CTRL, 8'h7f);
    chk(pb_oe, 8'h00);
    $display("test reserved done");
  endtask
  // strobed input with a slow panel, then strobed output
  task automatic t_strobe();
    wr(PPIO_ADDR_CTRL, 8'h86);
    chk(pa_oe, 8'hff);
    i_ppio_panel_model.strobe(8'h3c, 3);
    tick();
    chk(pc_out_n & 8'h06, 8'h00);
    rd_chk(PPIO_ADDR_SECOND, 8'h3c);
    chk(pc_out_n & 8'h06, 8'h06);
    wr(PPIO_ADDR_CTRL, 8'h84);
    wr(PPIO_ADDR_SECOND, 8'h96);
    chk(pb_oe, 8'hff);
    chk(pb_out_n, 8'h69);
    chk(pc_out_n & 8'h06, 8'h04);
    i_ppio_panel_model.strobe(8'h00, 2);
    tick();
    chk(pc_out_n & 8'h06, 8'h02);
    $display("test strobe done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset for four cycles, then each scenario in turn
  initial begin
    reset_n  = 1'b0;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = 8'h00;
    io_wdata = 8'h00;
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_modes();
    t_data();
    t_inputs();
    t_reserved();
    t_strobe();
    report_and_stop();
  end
endmodule  // panel_parallel_io_ports_tb_top
`default_nettype wire
